// *** core/fsc_params.svh ***
// Constants of the frequency setpoint combiner
`ifndef FSC_PARAMS_SVH
`define FSC_PARAMS_SVH

// ==========================================================
// Parameter codes on the parameter port
`define FSC_ADDR_MAIN_SRC 8'h03
`define FSC_ADDR_AUX_SRC 8'h04
`define FSC_ADDR_RANGE_BASE 8'h05
`define FSC_ADDR_AUX_PCT 8'h06
`define FSC_ADDR_COMBINE 8'h07
`define FSC_ADDR_PRESET 8'h08
`define FSC_ADDR_DIR_INV 8'h09
`define FSC_ADDR_MAX_FREQ 8'h0A
`define FSC_ADDR_BIAS 8'h15
`define FSC_ADDR_MS_A 8'h40
`define FSC_ADDR_MS_B 8'h41
`define FSC_ADDR_MS_C 8'h42

// ==========================================================
// Reset values and limits, frequency in 0.01 Hz, percent in 0.1 %
`define FSC_RST_MAIN_SRC 16'h0001
`define FSC_RST_ZERO 16'h0000
`define FSC_RST_PRESET 16'h1388
`define FSC_RST_MAX_FREQ 16'h1388
`define FSC_MAX_FREQ_LOW 16'h1388
`define FSC_MAX_FREQ_HIGH 16'hC350
`define FSC_AUX_PCT_HIGH 16'h0BB8
`define FSC_SRC_CODE_HIGH 16'h000A
`define FSC_COMBINE_HIGH 16'h0022
`define FSC_PCT_FULL 11'h3E8
`define FSC_PCT_DIV 27'h00003E8
`define FSC_RANGE_DIV 39'h00000F4240

// ==========================================================
// Channel codes
`define FSC_CH_DIG_VOLATILE 4'h0
`define FSC_CH_DIG_MEMORY 4'h1
`define FSC_CH_ANALOG_ONE 4'h2
`define FSC_CH_ANALOG_TWO 4'h3
`define FSC_CH_KEYPAD_POT 4'h4
`define FSC_CH_PULSE 4'h5
`define FSC_CH_MULTISTEP 4'h6
`define FSC_CH_PLC 4'h7
`define FSC_CH_PID 4'h8
`define FSC_CH_COMM 4'h9
`define FSC_CH_OPTICAL 4'hA

// ==========================================================
// Combining digits
`define FSC_U_X 3'h0
`define FSC_U_RESULT 3'h1
`define FSC_U_X_Y 3'h2
`define FSC_U_X_RES 3'h3
`define FSC_U_Y_RES 3'h4
`define FSC_U_HIGH 3'h4
`define FSC_T_SUM 2'h0
`define FSC_T_DIFF 2'h1
`define FSC_T_MAX 2'h2
`define FSC_T_MIN 2'h3

// ==========================================================
// Optical stage thresholds on the pulse percentage
`define FSC_OPT_LOW 11'h14E
`define FSC_OPT_HIGH 11'h29B

`endif

// *** core/fsc_pkg.sv ***
// Types of the frequency setpoint combiner
package fsc_pkg;
    typedef logic [15:0] fsc_freq_t;
    typedef logic [10:0] fsc_pct_t;
    typedef logic [3:0] fsc_chan_t;
    typedef logic signed [19:0] fsc_wide_t;
endpackage

// *** core/fsc_src_if.sv ***
// Setpoint producer percentages shared by the channel choosers
`timescale 1ns/1ns
interface fsc_src_if;
    fsc_pkg::fsc_pct_t analogOne;
    fsc_pkg::fsc_pct_t analogTwo;
    fsc_pkg::fsc_pct_t keypadPot;
    fsc_pkg::fsc_pct_t pulsePct;
    fsc_pkg::fsc_pct_t multistepPct;
    fsc_pkg::fsc_pct_t plcPct;
    fsc_pkg::fsc_pct_t pidPct;
    fsc_pkg::fsc_pct_t commPct;
    fsc_pkg::fsc_pct_t opticalPct;
    modport owner(output analogOne, analogTwo, keypadPot, pulsePct,
                  multistepPct, plcPct, pidPct, commPct);
    modport optic(input pulsePct, output opticalPct);
    modport chooser(input analogOne, analogTwo, keypadPot, pulsePct,
                    multistepPct, plcPct, pidPct, commPct, opticalPct);
endinterface

// *** core/fsc_channel_sel.sv ***
// Picks one setpoint channel by its code
`timescale 1ns/1ns
`include "fsc_params.svh"
module fsc_channel_sel
(
    // Selection
    input wire fsc_pkg::fsc_chan_t code,
    fsc_src_if.chooser src,
    // Result
    output logic isDigital,
    output fsc_pkg::fsc_pct_t pct
);
    // Same decode for X and Y, so Y alone behaves like X
    always_comb
    begin
        isDigital = 1'b0;
        unique case (code)
            `FSC_CH_DIG_VOLATILE, `FSC_CH_DIG_MEMORY:
            begin
                isDigital = 1'b1;
                pct = '0;
            end
            `FSC_CH_ANALOG_ONE: pct = src.analogOne;
            `FSC_CH_ANALOG_TWO: pct = src.analogTwo;
            `FSC_CH_KEYPAD_POT: pct = src.keypadPot;
            `FSC_CH_PULSE: pct = src.pulsePct;
            `FSC_CH_MULTISTEP: pct = src.multistepPct;
            `FSC_CH_PLC: pct = src.plcPct;
            `FSC_CH_PID: pct = src.pidPct;
            `FSC_CH_COMM: pct = src.commPct;
            `FSC_CH_OPTICAL: pct = src.opticalPct;
            default: pct = '0;
        endcase
    end
endmodule

// *** core/fsc_optical.sv ***
// Optical multi-stage speed from pulse level and three stage settings
`timescale 1ns/1ns
`include "fsc_params.svh"
module fsc_optical
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstN,
    // Stage settings, percent of max
    input wire fsc_pkg::fsc_pct_t stageA,
    input wire fsc_pkg::fsc_pct_t stageB,
    input wire fsc_pkg::fsc_pct_t stageC,
    // Producer side
    fsc_src_if.optic src
);
    // ==========================================================
    // Stage pick, one cycle late
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
            src.opticalPct <= '0;
        else if (src.pulsePct >= `FSC_OPT_HIGH)
            src.opticalPct <= stageC;
        else if (src.pulsePct >= `FSC_OPT_LOW)
            src.opticalPct <= stageB;
        else
            src.opticalPct <= stageA;
    end

    // ==========================================================
    // Checks
    a_optical_stage_c: assert property (@(posedge clk_sys)
        disable iff (!rstN) src.pulsePct >= `FSC_OPT_HIGH |=>
        src.opticalPct == $past(stageC))
        else $error("optical stage c not taken");
    a_optical_stage_a: assert property (@(posedge clk_sys)
        disable iff (!rstN) src.pulsePct < `FSC_OPT_LOW |=>
        src.opticalPct == $past(stageA))
        else $error("optical stage a not taken");
endmodule

// *** core/fsc_combiner.sv ***
// Frequency setpoint combiner top
`timescale 1ns/1ns
`include "fsc_params.svh"
module fsc_combiner
#(
    parameter logic [15:0] UPDOWN_STEP = 16'h0001
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Parameter port
    input wire logic paramWrite,
    input wire logic [7:0] paramAddr,
    input wire logic [15:0] paramWdata,
    input wire logic paramInit,
    output logic [15:0] paramRdata,
    // Setpoint producers, percent of max in 0.1 %
    input wire fsc_pkg::fsc_pct_t analogOne,
    input wire fsc_pkg::fsc_pct_t analogTwo,
    input wire fsc_pkg::fsc_pct_t keypadPot,
    input wire fsc_pkg::fsc_pct_t pulseInput,
    input wire fsc_pkg::fsc_pct_t multistepPct,
    input wire fsc_pkg::fsc_pct_t plcPct,
    input wire fsc_pkg::fsc_pct_t pidPct,
    input wire fsc_pkg::fsc_pct_t commPct,
    // Keypad and terminal up/down, one-cycle pulses
    input wire logic upStep,
    input wire logic downStep,
    // Source switch terminal pin
    input wire logic sourceSwitchPin,
    // Direction
    input wire logic dirCmd,
    output logic dirOut,
    // Setpoint
    output fsc_pkg::fsc_freq_t setpoint
);
    // ==========================================================
    // Reset release
    logic rstMeta;
    logic rstN;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rstMeta <= 1'b0;
            rstN <= 1'b0;
        end
        else
        begin
            rstMeta <= 1'b1;
            rstN <= rstMeta;
        end
    end

    // ==========================================================
    // Parameters
    fsc_pkg::fsc_chan_t mainSourceSelect;
    fsc_pkg::fsc_chan_t auxSourceSelect;
    logic auxRangeBaseSelect;
    logic [11:0] auxRangePercent;
    logic [5:0] sourceCombineSelect;
    fsc_pkg::fsc_freq_t presetFrequency;
    logic directionInvert;
    fsc_pkg::fsc_freq_t maxFrequency;
    logic signed [15:0] combineBiasFrequency;
    fsc_pkg::fsc_pct_t multistepA;
    fsc_pkg::fsc_pct_t multistepB;
    fsc_pkg::fsc_pct_t multistepC;

    logic srcCodeOk;
    logic pctOk;
    logic [15:0] wrUnits;
    assign srcCodeOk = paramWdata <= `FSC_SRC_CODE_HIGH;
    assign pctOk = paramWdata <= 16'(`FSC_PCT_FULL);
    assign wrUnits = paramWdata % 16'h000A;

    // Out-of-range writes are dropped; a later lower max frequency does not re-check the stored preset
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
        begin
            mainSourceSelect <= 4'(`FSC_RST_MAIN_SRC);
            auxSourceSelect <= '0;
            auxRangeBaseSelect <= 1'b0;
            auxRangePercent <= '0;
            sourceCombineSelect <= '0;
            presetFrequency <= `FSC_RST_PRESET;
            directionInvert <= 1'b0;
            maxFrequency <= `FSC_RST_MAX_FREQ;
            combineBiasFrequency <= '0;
            multistepA <= '0;
            multistepB <= '0;
            multistepC <= '0;
        end
        else if (paramInit)
        begin
            mainSourceSelect <= 4'(`FSC_RST_MAIN_SRC);
            auxSourceSelect <= '0;
            auxRangeBaseSelect <= 1'b0;
            auxRangePercent <= '0;
            sourceCombineSelect <= '0;
            presetFrequency <= `FSC_RST_PRESET;
            directionInvert <= 1'b0;
            maxFrequency <= `FSC_RST_MAX_FREQ;
            combineBiasFrequency <= '0;
            multistepA <= '0;
            multistepB <= '0;
            multistepC <= '0;
        end
        else if (paramWrite)
        begin
            unique case (paramAddr)
                `FSC_ADDR_MAIN_SRC:
                    if (srcCodeOk)
                        mainSourceSelect <= paramWdata[3:0];
                `FSC_ADDR_AUX_SRC:
                    if (srcCodeOk)
                        auxSourceSelect <= paramWdata[3:0];
                `FSC_ADDR_RANGE_BASE:
                    if (paramWdata <= 16'h0001)
                        auxRangeBaseSelect <= paramWdata[0];
                `FSC_ADDR_AUX_PCT:
                    if (paramWdata <= `FSC_AUX_PCT_HIGH)
                        auxRangePercent <= paramWdata[11:0];
                `FSC_ADDR_COMBINE:
                    if (paramWdata <= `FSC_COMBINE_HIGH &&
                        wrUnits <= 16'(`FSC_U_HIGH))
                        sourceCombineSelect <= paramWdata[5:0];
                `FSC_ADDR_PRESET:
                    if (paramWdata <= maxFrequency)
                        presetFrequency <= paramWdata;
                `FSC_ADDR_DIR_INV:
                    if (paramWdata <= 16'h0001)
                        directionInvert <= paramWdata[0];
                `FSC_ADDR_MAX_FREQ:
                    if (paramWdata >= `FSC_MAX_FREQ_LOW &&
                        paramWdata <= `FSC_MAX_FREQ_HIGH)
                        maxFrequency <= paramWdata;
                `FSC_ADDR_BIAS:
                    combineBiasFrequency <= paramWdata;
                `FSC_ADDR_MS_A:
                    if (pctOk)
                        multistepA <= paramWdata[10:0];
                `FSC_ADDR_MS_B:
                    if (pctOk)
                        multistepB <= paramWdata[10:0];
                `FSC_ADDR_MS_C:
                    if (pctOk)
                        multistepC <= paramWdata[10:0];
                default:
                begin
                end
            endcase
        end
    end

    // Read back one cycle after the code is presented
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
            paramRdata <= '0;
        else
        begin
            unique case (paramAddr)
                `FSC_ADDR_MAIN_SRC: paramRdata <= {12'h000, mainSourceSelect};
                `FSC_ADDR_AUX_SRC: paramRdata <= {12'h000, auxSourceSelect};
                `FSC_ADDR_RANGE_BASE:
                    paramRdata <= {15'h0000, auxRangeBaseSelect};
                `FSC_ADDR_AUX_PCT: paramRdata <= {4'h0, auxRangePercent};
                `FSC_ADDR_COMBINE:
                    paramRdata <= {10'h000, sourceCombineSelect};
                `FSC_ADDR_PRESET: paramRdata <= presetFrequency;
                `FSC_ADDR_DIR_INV: paramRdata <= {15'h0000, directionInvert};
                `FSC_ADDR_MAX_FREQ: paramRdata <= maxFrequency;
                `FSC_ADDR_BIAS: paramRdata <= combineBiasFrequency;
                `FSC_ADDR_MS_A: paramRdata <= {5'h00, multistepA};
                `FSC_ADDR_MS_B: paramRdata <= {5'h00, multistepB};
                `FSC_ADDR_MS_C: paramRdata <= {5'h00, multistepC};
                default: paramRdata <= '0;
            endcase
        end
    end

    // ==========================================================
    // Source switch pin, three stages
    logic swMeta;
    logic swMid;
    logic swLate;
    logic swState;

    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
        begin
            swMeta <= 1'b0;
            swMid <= 1'b0;
            swLate <= 1'b0;
            swState <= 1'b0;
        end
        else
        begin
            swMeta <= sourceSwitchPin;
            swMid <= swMeta;
            swLate <= swMid;
            if (swMid == swLate)
                swState <= swLate;
        end
    end

    // ==========================================================
    // Up/down correction, shared by digital X and digital Y
    logic signed [16:0] adj;
    logic signed [16:0] adjLimit;
    logic signed [16:0] stepS;
    assign adjLimit = $signed({1'b0, maxFrequency});
    assign stepS = $signed({1'b0, UPDOWN_STEP});

    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
            adj <= '0;
        else if (paramInit)
            adj <= '0;
        else if (upStep && !downStep)
            adj <= (adj + stepS > adjLimit) ? adjLimit : adj + stepS;
        else if (downStep && !upStep)
            adj <= (adj - stepS < -adjLimit) ? -adjLimit : adj - stepS;
    end

    // ==========================================================
    // Channel choice
    fsc_src_if srcBus();
    assign srcBus.analogOne = analogOne;
    assign srcBus.analogTwo = analogTwo;
    assign srcBus.keypadPot = keypadPot;
    assign srcBus.pulsePct = pulseInput;
    assign srcBus.multistepPct = multistepPct;
    assign srcBus.plcPct = plcPct;
    assign srcBus.pidPct = pidPct;
    assign srcBus.commPct = commPct;

    logic xDigital;
    logic yDigital;
    fsc_pkg::fsc_pct_t xPctRaw;
    fsc_pkg::fsc_pct_t yPctRaw;

    fsc_optical uOptical (
        .clk_sys(clk_sys),
        .rstN(rstN),
        .stageA(multistepA),
        .stageB(multistepB),
        .stageC(multistepC),
        .src(srcBus.optic)
    );
    fsc_channel_sel uChanX (
        .code(mainSourceSelect),
        .src(srcBus.chooser),
        .isDigital(xDigital),
        .pct(xPctRaw)
    );
    fsc_channel_sel uChanY (
        .code(auxSourceSelect),
        .src(srcBus.chooser),
        .isDigital(yDigital),
        .pct(yPctRaw)
    );

    // ==========================================================
    // Arithmetic
    function automatic fsc_pkg::fsc_freq_t clampF(
        input fsc_pkg::fsc_wide_t v, input fsc_pkg::fsc_freq_t m);
        if (v < 0)
            return '0;
        else if (v > $signed({4'h0, m}))
            return m;
        else
            return v[15:0];
    endfunction

    fsc_pkg::fsc_pct_t xPct;
    fsc_pkg::fsc_pct_t yPct;
    logic [26:0] xProd;
    logic [26:0] yProd;
    logic [38:0] yRangeProd;
    fsc_pkg::fsc_freq_t digVal;
    fsc_pkg::fsc_freq_t rangeBase;
    fsc_pkg::fsc_wide_t xVal;
    fsc_pkg::fsc_wide_t yComb;
    fsc_pkg::fsc_wide_t yAlone;
    fsc_pkg::fsc_wide_t res;
    fsc_pkg::fsc_wide_t resBiased;
    fsc_pkg::fsc_wide_t chosen;
    logic [2:0] units;
    logic [1:0] tens;

    assign units = 3'(sourceCombineSelect % 6'h0A);
    assign tens = 2'(sourceCombineSelect / 6'h0A);
    // Inputs above full scale are held at full scale
    assign xPct = (xPctRaw > `FSC_PCT_FULL) ? `FSC_PCT_FULL : xPctRaw;
    assign yPct = (yPctRaw > `FSC_PCT_FULL) ? `FSC_PCT_FULL : yPctRaw;
    assign digVal = clampF(20'($signed({4'h0, presetFrequency}) + adj),
                           maxFrequency);
    assign rangeBase = auxRangeBaseSelect ? xVal[15:0] : maxFrequency;
    assign xProd = 27'(xPct) * 27'(maxFrequency);
    assign yProd = 27'(yPct) * 27'(maxFrequency);
    assign yRangeProd = 39'(yPct) * 39'(rangeBase) * 39'(auxRangePercent);

    always_comb
    begin
        // Full scale maps to max frequency
        xVal = xDigital ? 20'(digVal) : 20'(xProd / `FSC_PCT_DIV);
        yAlone = yDigital ? 20'(digVal) : 20'(yProd / `FSC_PCT_DIV);
        // Combined: digital Y is the bare correction, preset ignored
        if (yDigital)
            yComb = 20'(adj);
        else
            yComb = 20'(yRangeProd / `FSC_RANGE_DIV);
        unique case (tens)
            `FSC_T_SUM: res = xVal + yComb;
            `FSC_T_DIFF: res = xVal - yComb;
            `FSC_T_MAX: res = (xVal > yComb) ? xVal : yComb;
            `FSC_T_MIN: res = (xVal < yComb) ? xVal : yComb;
        endcase
        resBiased = res + 20'(combineBiasFrequency);
        unique case (units)
            `FSC_U_X: chosen = xVal;
            `FSC_U_RESULT: chosen = resBiased;
            `FSC_U_X_Y: chosen = swState ? yAlone : xVal;
            `FSC_U_X_RES: chosen = swState ? resBiased : xVal;
            `FSC_U_Y_RES: chosen = swState ? resBiased : yAlone;
            default: chosen = xVal;
        endcase
    end

    // ==========================================================
    // Outputs
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
            setpoint <= '0;
        else
            setpoint <= clampF(chosen, maxFrequency);
    end

    // Reversal stands in for swapping two motor phases
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
            dirOut <= 1'b0;
        else
            dirOut <= dirCmd ^ directionInvert;
    end

    // ==========================================================
    // Checks
    a_setpoint_within_max: assert property (@(posedge clk_sys)
        disable iff (!rstN) setpoint <= $past(maxFrequency))
        else $error("setpoint above max frequency");
    a_dir_follows_invert: assert property (@(posedge clk_sys)
        disable iff (!rstN)
        ##1 dirOut == ($past(dirCmd) ^ $past(directionInvert)))
        else $error("direction sense wrong");
    a_init_clears_dir: assert property (@(posedge clk_sys)
        disable iff (!rstN) paramInit |=>
        !directionInvert && presetFrequency == `FSC_RST_PRESET)
        else $error("init left direction or preset");
    a_max_in_range: assert property (@(posedge clk_sys)
        disable iff (!rstN) maxFrequency >= `FSC_MAX_FREQ_LOW &&
        maxFrequency <= `FSC_MAX_FREQ_HIGH)
        else $error("max frequency out of range");
    a_aux_pct_range: assert property (@(posedge clk_sys)
        disable iff (!rstN) auxRangePercent <= 12'(`FSC_AUX_PCT_HIGH))
        else $error("aux range percent out of range");
    a_aux_code_legal: assert property (@(posedge clk_sys)
        disable iff (!rstN) auxSourceSelect <= 4'(`FSC_SRC_CODE_HIGH))
        else $error("aux source code illegal");
    a_x_only_mode: assert property (@(posedge clk_sys)
        disable iff (!rstN) units == `FSC_U_X |=>
        setpoint == clampF($past(xVal), $past(maxFrequency)))
        else $error("x only mode wrong");
    a_analog_full_scale: assert property (@(posedge clk_sys)
        disable iff (!rstN)
        units == `FSC_U_X && mainSourceSelect == `FSC_CH_ANALOG_ONE &&
        analogOne == `FSC_PCT_FULL |=> setpoint == $past(maxFrequency))
        else $error("full analog not max frequency");
    a_sum_with_bias: assert property (@(posedge clk_sys)
        disable iff (!rstN)
        units == `FSC_U_RESULT && tens == `FSC_T_SUM |=> setpoint ==
        clampF($past(xVal + yComb + 20'(combineBiasFrequency)),
               $past(maxFrequency)))
        else $error("sum with bias wrong");
    a_digital_aux_adj: assert property (@(posedge clk_sys)
        disable iff (!rstN) yDigital && units == `FSC_U_RESULT |->
        yComb == 20'(adj))
        else $error("digital aux not bare correction");

    c_switch_to_y: cover property (@(posedge clk_sys) disable iff (!rstN)
        units == `FSC_U_X_Y && swState ##1 setpoint != 16'h0000);
    c_diff_mode: cover property (@(posedge clk_sys) disable iff (!rstN)
        units == `FSC_U_RESULT && tens == `FSC_T_DIFF);
    c_clamp_hit: cover property (@(posedge clk_sys) disable iff (!rstN)
        chosen > $signed({4'h0, maxFrequency}));
    c_optical_main: cover property (@(posedge clk_sys) disable iff (!rstN)
        mainSourceSelect == `FSC_CH_OPTICAL && units == `FSC_U_X);
endmodule

// *** verification/fsc_source_model.sv ***
// Setpoint producer model holding percentages between refreshes
`timescale 1ns/1ns
module fsc_source_model
(
    // Clock and request
    input wire logic clk_sys,
    input wire logic refresh,
    // Producer percentages
    output fsc_pkg::fsc_pct_t pct [8]
);
    fsc_pkg::fsc_pct_t held [8] = '{default: 11'h000};
    int n = 0;
    assign pct = held;
    // Never above full scale; every fifth refresh sits exactly on it
    always @(posedge clk_sys)
        if (refresh)
        begin
            foreach (held[i])
                held[i] <= (n % 5 == 0) ? 11'h3E8
                    : 11'($urandom_range(1000));
            n <= n + 1;
        end
endmodule

// *** verification/test_frequency_setpoint_combiner.sv ***
// Self-checking bench for the frequency setpoint combiner
`timescale 1ns/1ns
module test_frequency_setpoint_combiner;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic paramWrite = 1'b0;
    logic paramInit = 1'b0;
    logic upStep = 1'b0;
    logic downStep = 1'b0;
    logic sourceSwitchPin = 1'b0;
    logic dirCmd = 1'b0;
    logic refresh = 1'b0;
    logic [7:0] paramAddr = 8'h00;
    logic [15:0] paramWdata = 16'h0000;
    logic [15:0] paramRdata;
    logic [15:0] rst [7] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h1388, 16'h0,
                             16'h1388};
    logic dirOut;
    fsc_pkg::fsc_freq_t setpoint;
    fsc_pkg::fsc_pct_t pct [8];
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    int mx = 50000;
    int ap, bs, u, t, sw;
    always #25 clk_sys = ~clk_sys;
    fsc_source_model fsc_source_model_inst (.clk_sys(clk_sys),
        .refresh(refresh), .pct(pct));
    fsc_combiner fsc_combiner_inst (.clk_sys(clk_sys), .resetn(resetn),
        .paramWrite(paramWrite), .paramAddr(paramAddr),
        .paramWdata(paramWdata), .paramInit(paramInit),
        .paramRdata(paramRdata), .analogOne(pct[0]), .analogTwo(pct[1]),
        .keypadPot(pct[2]), .pulseInput(pct[3]), .multistepPct(pct[4]),
        .plcPct(pct[5]), .pidPct(pct[6]), .commPct(pct[7]),
        .upStep(upStep), .downStep(downStep),
        .sourceSwitchPin(sourceSwitchPin),
        .dirCmd(dirCmd), .dirOut(dirOut), .setpoint(setpoint));
    // ==========================================================
    // Tasks
    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        paramWrite <= 1'b1;
        paramAddr <= a;
        paramWdata <= d;
        @(posedge clk_sys);
        paramWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        paramAddr <= a;
        repeat (2) @(posedge clk_sys);
        #1 cmp(paramRdata, e);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Bias lands first, then one clamp to zero through max
    function automatic longint predict();
        longint x, ya, yc, r;
        x = pct[0] * mx / 1000;
        ya = pct[1] * mx / 1000;
        yc = longint'(pct[1]) * (bs ? x : mx) * ap / 1000000;
        r = t == 0 ? x + yc : t == 1 ? x - yc : t == 2 ? (x > yc ? x : yc)
            : (x < yc ? x : yc);
        r = r + 100;
        r = u == 0 ? x : u == 1 ? r : u == 2 ? (sw ? ya : x)
            : u == 3 ? (sw ? r : x) : (sw ? r : ya);
        return r < 0 ? 0 : r > mx ? mx : r;
    endfunction
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            complete_run();
        end
    end
    // ==========================================================
    // Main sequence
    initial
    begin
        void'($urandom(32'hCA58));
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        step(3);
        foreach (rst[i]) rd(8'(i + 4), rst[i]);
        wr(8'h0A, 16'h1387);
        rd(8'h0A, 16'h1388);
        wr(8'h0A, 16'hC350);
        rd(8'h0A, 16'hC350);
        $display("test done: parameters");
        wr(8'h03, 16'h0002);
        wr(8'h04, 16'h0003);
        wr(8'h15, 16'h0064);
        for (int i = 0; i < 40; i++)
        begin
            ap = $urandom_range(3000);
            bs = $urandom_range(1);
            sw = $urandom_range(1);
            u = i % 5;
            t = (i / 5) % 4;
            wr(8'h06, 16'(ap));
            wr(8'h05, 16'(bs));
            wr(8'h07, 16'(t * 10 + u));
            sourceSwitchPin <= sw[0];
            refresh <= 1'b1;
            @(posedge clk_sys);
            refresh <= 1'b0;
            step(6);
            cmp(setpoint, 16'(predict()));
        end
        $display("test done: combining");
        wr(8'h40, 16'h0064);
        wr(8'h41, 16'h01F4);
        wr(8'h42, 16'h03E8);
        wr(8'h03, 16'h000A);
        wr(8'h07, 16'h0000);
        repeat (4)
        begin
            @(posedge clk_sys);
            refresh <= 1'b1;
            @(posedge clk_sys);
            refresh <= 1'b0;
            step(4);
            ap = pct[3] >= 667 ? 1000 : pct[3] >= 334 ? 500 : 100;
            cmp(setpoint, 16'(ap * mx / 1000));
        end
        $display("test done: optical");
        wr(8'h09, 16'h0001);
        dirCmd <= 1'b1;
        step(3);
        cmp(16'(dirOut), 16'h0000);
        @(posedge clk_sys);
        paramInit <= 1'b1;
        @(posedge clk_sys);
        paramInit <= 1'b0;
        step(3);
        cmp(16'(dirOut), 16'h0001);
        cmp(setpoint, 16'h1388);
        wr(8'h0A, 16'hC350);
        @(posedge clk_sys);
        upStep <= 1'b1;
        @(posedge clk_sys);
        upStep <= 1'b0;
        step(3);
        cmp(setpoint, 16'h1389);
        wr(8'h07, 16'h0001);
        step(3);
        cmp(setpoint, 16'h138A);
        @(posedge clk_sys);
        downStep <= 1'b1;
        repeat (2) @(posedge clk_sys);
        downStep <= 1'b0;
        step(3);
        cmp(setpoint, 16'h1386);
        $display("test done: direction and preset");
        complete_run();
    end
endmodule
